// >>> inc/lpm_pkg.sv
// constants and types for the low-power mode controller
package lpm_pkg;

  // ----------------------------------------------------------------
  // mode request encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] REQ_SLEEP   = 2'h1;
  localparam logic [1:0] REQ_STOP    = 2'h2;
  localparam logic [1:0] REQ_STANDBY = 2'h3;

  // ----------------------------------------------------------------
  // wake source widths and positions
  // ----------------------------------------------------------------
  localparam int EXT_PIN_LINES = 16;
  localparam int EVT_IDX_PVD   = 0;
  localparam int EVT_IDX_USB   = 1;
  localparam int EVT_IDX_RTC   = 2;
  localparam int EVT_IDX_COMP  = 3;
  localparam int EVT_IDX_USART = 4;
  localparam int INT_EVT_BITS  = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int OSC_SETTLE_NS      = 100;
  localparam int OSC_SETTLE_CYC     = (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_HOLD_NS      = 200;
  localparam int RESET_HOLD_CYC     = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W              = 8;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STOP,
    ST_STOP_WAKE,
    ST_STANDBY,
    ST_WAKE_RESET
  } lpm_state_e;

endpackage : lpm_pkg

// >>> verilog/low_power_mode_controller.sv
// low-power mode controller: mode sequencing, clock/power gating, wake
`timescale 1ns/100ps

module low_power_mode_controller #(
  parameter int N_EXT_LINES = lpm_pkg::EXT_PIN_LINES,
  parameter int N_I2C       = 2
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // core request side
  input  wire logic                   mode_req_valid,
  input  wire logic [1:0]             mode_req,
  input  wire logic                   regulator_lp_sel,
  input  wire logic                   periph_irq,
  // wake sources
  input  wire logic [N_EXT_LINES-1:0] external_event_lines,
  input  wire logic                   supply_voltage_monitor,
  input  wire logic                   usb_wakeup,
  input  wire logic                   rtc_alarm,
  input  wire logic                   analog_comparators,
  input  wire logic                   usart_wakeup,
  input  wire logic [N_I2C-1:0]       i2c_addr_match,
  input  wire logic [N_I2C-1:0]       i2c_digital_filter_en,
  input  wire logic                   wakeup_pin,
  input  wire logic                   external_reset_pin,
  input  wire logic                   independent_watchdog,
  // clock and power controls
  output logic                        cpu_clk_en,
  output logic                        core_clk_en,
  output logic                        pll_en,
  output logic                        internal_fast_osc_en,
  output logic                        external_fast_osc_en,
  output logic                        regulator_on,
  output logic                        regulator_lp,
  output logic                        retention_en,
  output logic                        lowspeed_domain_en,
  output logic                        core_reset_n,
  output logic                        backup_keep,
  // status
  output logic                        in_sleep,
  output logic                        in_stop,
  output logic                        in_standby,
  output logic                        wake_pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lpm_pkg::lpm_state_e       st;
    logic [lpm_pkg::CNT_W-1:0] cnt;
    logic                      wkp_prev;
    logic                      cpu_clk_en;
    logic                      core_clk_en;
    logic                      pll_en;
    logic                      int_osc_en;
    logic                      ext_osc_en;
    logic                      ls_en;
    logic                      bk_keep;
    logic                      reg_on;
    logic                      reg_lp;
    logic                      retain;
    logic                      core_rst_n;
    logic                      in_sleep;
    logic                      in_stop;
    logic                      in_standby;
    logic                      wake_pulse;
  } lpm_s;

  lpm_s s_q;
  lpm_s s_d;

  // ----------------------------------------------------------------
  // wake decode
  // ----------------------------------------------------------------
  logic [N_I2C-1:0] i2c_wake;
  logic             stop_wake;
  logic             standby_wake;
  logic             wkp_rise;

  genvar gi;
  generate
    for (gi = 0; gi < N_I2C; gi++)
    begin : g_i2c
      assign i2c_wake[gi] = i2c_addr_match[gi] & ~i2c_digital_filter_en[gi];
    end
  endgenerate

  assign stop_wake = (|external_event_lines) | supply_voltage_monitor | usb_wakeup
                   | rtc_alarm | analog_comparators | usart_wakeup
                   | (|i2c_wake);

  assign wkp_rise     = wakeup_pin & ~s_q.wkp_prev;
  assign standby_wake = external_reset_pin | independent_watchdog
                      | wkp_rise | rtc_alarm;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d            = s_q;
    s_d.wkp_prev   = wakeup_pin;
    s_d.wake_pulse = 1'b0;
    unique case (s_q.st)
      lpm_pkg::ST_RUN:
      begin
        if (mode_req_valid && mode_req == lpm_pkg::REQ_SLEEP)
        begin
          s_d.st         = lpm_pkg::ST_SLEEP;
          s_d.cpu_clk_en = 1'b0;
          s_d.in_sleep   = 1'b1;
        end
        else if (mode_req_valid && mode_req == lpm_pkg::REQ_STOP)
        begin
          s_d.st          = lpm_pkg::ST_STOP;
          s_d.cpu_clk_en  = 1'b0;
          s_d.core_clk_en = 1'b0;
          s_d.pll_en      = 1'b0;
          s_d.int_osc_en  = 1'b0;
          s_d.ext_osc_en  = 1'b0;
          s_d.reg_lp      = regulator_lp_sel;
          s_d.retain      = 1'b1;
          s_d.in_stop     = 1'b1;
        end
        else if (mode_req_valid && mode_req == lpm_pkg::REQ_STANDBY)
        begin
          s_d.st          = lpm_pkg::ST_STANDBY;
          s_d.cpu_clk_en  = 1'b0;
          s_d.core_clk_en = 1'b0;
          s_d.pll_en      = 1'b0;
          s_d.int_osc_en  = 1'b0;
          s_d.ext_osc_en  = 1'b0;
          s_d.reg_on      = 1'b0;
          s_d.reg_lp      = 1'b0;
          s_d.retain      = 1'b0;
          s_d.core_rst_n  = 1'b0;
          s_d.in_standby  = 1'b1;
        end
      end
      lpm_pkg::ST_SLEEP:
      begin
        if (periph_irq || stop_wake)
        begin
          s_d.st         = lpm_pkg::ST_RUN;
          s_d.cpu_clk_en = 1'b1;
          s_d.in_sleep   = 1'b0;
          s_d.wake_pulse = 1'b1;
        end
      end
      lpm_pkg::ST_STOP:
      begin
        if (stop_wake)
        begin
          s_d.st     = lpm_pkg::ST_STOP_WAKE;
          s_d.int_osc_en = 1'b1;
          s_d.reg_lp     = 1'b0;
          s_d.cnt    = lpm_pkg::CNT_W'(lpm_pkg::OSC_SETTLE_CYC - 1);
        end
      end
      lpm_pkg::ST_STOP_WAKE:
      begin
        // restart the fast oscillator, then resume from retained state
        if (s_q.cnt == '0)
        begin
          s_d.st          = lpm_pkg::ST_RUN;
          s_d.ext_osc_en  = 1'b1;
          s_d.pll_en      = 1'b1;
          s_d.core_clk_en = 1'b1;
          s_d.cpu_clk_en  = 1'b1;
          s_d.retain      = 1'b0;
          s_d.in_stop     = 1'b0;
          s_d.wake_pulse  = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      lpm_pkg::ST_STANDBY:
      begin
        if (standby_wake)
        begin
          s_d.st     = lpm_pkg::ST_WAKE_RESET;
          s_d.reg_on     = 1'b1;
          s_d.int_osc_en = 1'b1;
          s_d.cnt    = lpm_pkg::CNT_W'(lpm_pkg::RESET_HOLD_CYC - 1);
        end
      end
      lpm_pkg::ST_WAKE_RESET:
      begin
        // core held in reset while supply and oscillator settle
        if (s_q.cnt == '0)
        begin
          s_d.st          = lpm_pkg::ST_RUN;
          s_d.core_rst_n  = 1'b1;
          s_d.ext_osc_en  = 1'b1;
          s_d.pll_en      = 1'b1;
          s_d.core_clk_en = 1'b1;
          s_d.cpu_clk_en  = 1'b1;
          s_d.in_standby  = 1'b0;
          s_d.wake_pulse  = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      default:
      begin
        s_d.st = lpm_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q             <= '0;
      s_q.st          <= lpm_pkg::ST_RUN;
      s_q.cpu_clk_en  <= 1'b1;
      s_q.core_clk_en <= 1'b1;
      s_q.pll_en      <= 1'b1;
      s_q.int_osc_en  <= 1'b1;
      s_q.ext_osc_en  <= 1'b1;
      s_q.ls_en       <= 1'b1;
      s_q.bk_keep     <= 1'b1;
      s_q.reg_on      <= 1'b1;
      s_q.core_rst_n  <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cpu_clk_en           = s_q.cpu_clk_en;
  assign core_clk_en          = s_q.core_clk_en;
  assign pll_en               = s_q.pll_en;
  assign internal_fast_osc_en = s_q.int_osc_en;
  assign external_fast_osc_en = s_q.ext_osc_en;
  assign regulator_on         = s_q.reg_on;
  assign regulator_lp         = s_q.reg_lp;
  assign retention_en         = s_q.retain;
  assign core_reset_n         = s_q.core_rst_n;
  assign in_sleep             = s_q.in_sleep;
  assign in_stop              = s_q.in_stop;
  assign in_standby           = s_q.in_standby;
  assign wake_pulse           = s_q.wake_pulse;
  // low-speed domain and backup retention never gated
  assign lowspeed_domain_en   = s_q.ls_en;
  assign backup_keep          = s_q.bk_keep;

endmodule : low_power_mode_controller

// >>> tb/cpu_core_model.sv
// cpu core model issuing one mode request and waiting for the return
`timescale 1ns/100ps
module cpu_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // bench command
  input  wire logic       go,
  input  wire logic [1:0] mode,
  // controller side
  input  wire logic       wake_pulse,
  output logic            mode_req_valid,
  output logic [1:0]      mode_req
);
  logic busy_q;
  // no new request until the controller signals the return to run
  always @(negedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_req_valid <= 1'h0;
      mode_req       <= 2'h0;
      busy_q         <= 1'h0;
    end
    else
    begin
      mode_req_valid <= go && !busy_q;
      mode_req       <= mode;
      if (go && !busy_q)
        busy_q <= 1'h1;
      else if (wake_pulse)
        busy_q <= 1'h0;
    end
  end
endmodule : cpu_core_model

// >>> tb/low_power_mode_controller_props.sv
// assertions on the low-power mode controller ports
`timescale 1ns/100ps
module low_power_mode_controller_props #(
  parameter int N_EXT_LINES = 16,
  parameter int N_I2C       = 2
) (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic                   regulator_lp_sel,
  input wire logic                   periph_irq,
  input wire logic [N_EXT_LINES-1:0] external_event_lines,
  input wire logic                   supply_voltage_monitor,
  input wire logic                   usb_wakeup,
  input wire logic                   rtc_alarm,
  input wire logic                   analog_comparators,
  input wire logic                   usart_wakeup,
  input wire logic [N_I2C-1:0]       i2c_addr_match,
  input wire logic [N_I2C-1:0]       i2c_digital_filter_en,
  input wire logic                   wakeup_pin,
  input wire logic                   external_reset_pin,
  input wire logic                   independent_watchdog,
  input wire logic                   cpu_clk_en,
  input wire logic                   core_clk_en,
  input wire logic                   pll_en,
  input wire logic                   internal_fast_osc_en,
  input wire logic                   external_fast_osc_en,
  input wire logic                   regulator_on,
  input wire logic                   regulator_lp,
  input wire logic                   retention_en,
  input wire logic                   lowspeed_domain_en,
  input wire logic                   core_reset_n,
  input wire logic                   backup_keep,
  input wire logic                   in_sleep,
  input wire logic                   in_stop,
  input wire logic                   in_standby,
  input wire logic                   wake_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic stop_src;
  assign stop_src = (|external_event_lines) | supply_voltage_monitor | usb_wakeup | rtc_alarm
    | analog_comparators | usart_wakeup | (|(i2c_addr_match & ~i2c_digital_filter_en));
  sequence stop_wake_s;
    internal_fast_osc_en && in_stop ##25 wake_pulse && !in_stop && core_clk_en;
  endsequence
  sequence stby_wake_s;
    regulator_on && !core_reset_n ##50 wake_pulse && core_reset_n;
  endsequence
  sequence stby_cause_s;
    in_standby && !regulator_on
      && (external_reset_pin || independent_watchdog || rtc_alarm || $rose(wakeup_pin));
  endsequence
  a_sleep_cpu_only: assert property (in_sleep |-> !cpu_clk_en && core_clk_en && pll_en)
    else $error("sleep gated more than the cpu clock");
  a_sleep_irq_wake: assert property (in_sleep && periph_irq |=> !in_sleep && wake_pulse)
    else $error("sleep did not resume on interrupt");
  a_stop_clk_gate: assert property (in_stop |-> !core_clk_en && !pll_en && !external_fast_osc_en)
    else $error("stop left a core clock running");
  a_stop_retain: assert property (in_stop |-> retention_en && regulator_on && core_reset_n)
    else $error("stop lost retention");
  a_stop_reg_sel: assert property ($rose(in_stop) |-> regulator_lp == $past(regulator_lp_sel))
    else $error("regulator setting not taken at stop entry");
  a_stop_wake_seq: assert property (in_stop && !internal_fast_osc_en && stop_src |=> stop_wake_s)
    else $error("stop wake sequence wrong");
  a_stop_no_cause: assert property (in_stop && !internal_fast_osc_en && !stop_src |=> !internal_fast_osc_en)
    else $error("stop woke without an open source");
  a_stby_power_off: assert property (in_standby && !regulator_on |-> !pll_en && !internal_fast_osc_en
    && !external_fast_osc_en && !core_reset_n && !retention_en)
    else $error("standby left power or clocks on");
  a_stby_exit: assert property (stby_cause_s |=> stby_wake_s)
    else $error("standby exit sequence wrong");
  a_stby_refuse: assert property (in_standby && !regulator_on && !external_reset_pin
    && !independent_watchdog && !rtc_alarm && !wakeup_pin |=> !regulator_on)
    else $error("standby woke without a standby source");
  a_always_on: assert property (lowspeed_domain_en && backup_keep)
    else $error("always-on domain dropped");
endmodule : low_power_mode_controller_props

// >>> tb/low_power_mode_controller_tb.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
`define RUNV {cpu_clk_en, core_clk_en, pll_en, internal_fast_osc_en, external_fast_osc_en, \
  regulator_on, core_reset_n, in_sleep, in_stop, in_standby}
module low_power_mode_controller_tb;
  logic        clk;
  logic        arst_n;
  logic        go;
  logic [1:0]  mode;
  logic        regulator_lp_sel;
  logic        periph_irq;
  logic [15:0] external_event_lines;
  logic [8:0]  src;
  logic [1:0]  i2c_digital_filter_en;
  logic [1:0]  mode_req;
  logic        mode_req_valid;
  logic cpu_clk_en, core_clk_en, pll_en, internal_fast_osc_en, external_fast_osc_en;
  logic regulator_on, regulator_lp, retention_en, lowspeed_domain_en, core_reset_n;
  logic backup_keep, in_sleep, in_stop, in_standby, wake_pulse;
  wire logic supply_voltage_monitor = src[0];
  wire logic usb_wakeup = src[1];
  wire logic rtc_alarm = src[2];
  wire logic analog_comparators = src[3];
  wire logic usart_wakeup = src[4];
  wire logic [1:0] i2c_addr_match = {2{src[5]}};
  wire logic external_reset_pin = src[6];
  wire logic independent_watchdog = src[7];
  wire logic wakeup_pin = src[8];
  int checked = 0;
  int n_fail = 0;
  int cyc = 0;
  int sb[4] = '{2, 6, 7, 8};
  low_power_mode_controller low_power_mode_controller_inst (.*);
  cpu_core_model cpu_core_model_inst (.clk(clk), .arst_n(arst_n), .go(go), .mode(mode),
    .wake_pulse(wake_pulse), .mode_req_valid(mode_req_valid), .mode_req(mode_req));
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic wake_in(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (wake_pulse !== 1'h1 && n < 300);
    src <= 9'h0;
    external_event_lines <= 16'h0;
    periph_irq <= 1'h0;
  endtask : wake_in
  task automatic req(input logic [1:0] m, input logic sel);
    go <= 1'h1;
    mode <= m;
    regulator_lp_sel <= sel;
    @(negedge clk);
    go <= 1'h0;
    @(negedge clk);
  endtask : req
  task automatic t_reset;
    arst_n <= 1'h0;
    repeat (10) @(negedge clk);
    arst_n <= 1'h1;
    @(negedge clk);
    `CHK(`RUNV, 10'h3f8)
    `CHK({retention_en, wake_pulse, lowspeed_domain_en, backup_keep}, 4'h3)
  endtask : t_reset
  task automatic t_sleep;
    int n;
    req(lpm_pkg::REQ_SLEEP, 1'h0);
    `CHK({in_sleep, cpu_clk_en, core_clk_en, pll_en, internal_fast_osc_en}, 5'h17)
    periph_irq <= 1'h1;
    wake_in(n);
    `CHK(n, 1)
    `CHK(`RUNV, 10'h3f8)
  endtask : t_sleep
  task automatic t_stop(input int i, input logic [1:0] f);
    int n;
    i2c_digital_filter_en <= f;
    req(lpm_pkg::REQ_STOP, i[0]);
    `CHK({`RUNV, retention_en, regulator_lp}, {10'h01a, 1'h1, i[0]})
    if (i < 16)
      external_event_lines[i] <= 1'h1;
    else
      src[i-16] <= 1'h1;
    if (f == 2'h3)
    begin
      repeat (40) @(negedge clk);
      `CHK({in_stop, internal_fast_osc_en}, 2'h2)
      i2c_digital_filter_en <= 2'h2;
    end
    wake_in(n);
    `CHK(n, 26)
    `CHK(`RUNV, 10'h3f8)
  endtask : t_stop
  task automatic t_stby(input int b);
    int n;
    req(lpm_pkg::REQ_STANDBY, 1'h0);
    `CHK({pll_en, internal_fast_osc_en, external_fast_osc_en, regulator_on, core_reset_n,
      retention_en, in_standby}, 7'h01)
    src[1] <= 1'h1;
    external_event_lines <= 16'hffff;
    repeat (8) @(negedge clk);
    `CHK({in_standby, regulator_on, lowspeed_domain_en}, 3'h5)
    src[b] <= 1'h1;
    wake_in(n);
    `CHK(n, 51)
    `CHK(`RUNV, 10'h3f8)
  endtask : t_stby
  initial
  begin
    arst_n = 1'h0;
    go = 1'h0;
    mode = 2'h0;
    regulator_lp_sel = 1'h0;
    periph_irq = 1'h0;
    external_event_lines = 16'h0;
    src = 9'h0;
    i2c_digital_filter_en = 2'h0;
    @(negedge clk);
    t_reset();
    t_sleep();
    for (int i = 0; i < 22; i++)
      t_stop(i, 2'h1);
    t_stop(21, 2'h3);
    foreach (sb[k])
      t_stby(sb[k]);
    req(lpm_pkg::REQ_STOP, 1'h1);
    t_reset();
    end_of_test();
  end
endmodule : low_power_mode_controller_tb
bind low_power_mode_controller low_power_mode_controller_props #(.N_EXT_LINES(N_EXT_LINES),
  .N_I2C(N_I2C)) props_inst (.*);
